// ===== hdl/fpec_ctrl.sv
// fpec_ctrl: program/erase sequencing register set for the on-chip flash.
// assumes a same-clock register port and a flash array that reports a
// failed program or erase on array_fail_i, asynchronous to mclk_i.
//
// Operation
// - a program covers one 64-byte unit starting at low byte 00/40/80/c0
// - erase acts on one block: four of 1 kbyte, two of 4 kbytes
// - bit 7 of the control register always reads zero
// - software write enable at bit 6 enables program and erase
// - with write enable low, other control and block bits stay zero
// - erase setup bit 5 enters and leaves the erase setup state
// - program setup bit 4 enters and leaves the program setup state
// - erase-verify bit 3 enters and leaves erase-verify mode
// - program-verify bit 2 enters and leaves program-verify mode
// - erase bit 1 takes effect only with write enable and erase setup
// - program bit 0 takes effect only with write enable and program setup
// - block select bits 0-3 are 1-kbyte blocks, bits 4-5 the 4-kbyte ones
// - several block bits at once, or write enable low, clears block select
// - a failed program or erase sets a read-only error flag, bit 7
// - control, status and block registers need access enable bit 7
module fpec_ctrl
#(
    parameter int ADDR_W = fpec_pkg::ADDR_W,
    parameter int DATA_W = fpec_pkg::DATA_W
)
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic irq_o,
    input wire logic array_fail_i,
    output logic erase_setup_o,
    output logic program_setup_o,
    output logic erase_mode_o,
    output logic program_mode_o,
    output logic erase_verify_o,
    output logic program_verify_o,
    output logic error_protect_o,
    output logic [5:0] erase_block_o,
    output logic [15:0] prog_addr_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [6:0] ctrl;
    logic [6:0] next_ctrl;
    logic [5:0] ebs;
    logic [5:0] next_ebs;
    logic acc_en;
    logic err_flag;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_stat;
    logic [2:0] irq_evt;
    logic [15:0] paddr;
    logic fail_sync;
    logic unit_ok;
    logic [5:0] unit_block;
    logic [DATA_W-1:0] rd_mux;
    logic hit_ctrl;
    logic hit_err;
    logic hit_ebs;
    logic hit_locked;
    logic wr_ctrl;
    logic wr_ebs;
    logic deny_evt;
    logic fail_evt;
    logic align_evt;
    logic w_swe;
    logic w_esu;
    logic w_psu;
    logic w_e;
    logic w_p;
    logic busy;

    // more than one bit set in a block selection
    function automatic logic multi_hot(input logic [5:0] v);
        multi_hot = (v & (v - 6'h01)) != 6'h00;
    endfunction

    // ************************************************************
    // submodules
    // ************************************************************
    // the array's fail line runs on its own timing, so it is synchronised
    fpec_sync2 u_fail_sync
    (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .async_i(array_fail_i),
        .sync_o(fail_sync)
    );

    fpec_unit_check u_unit
    (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .addr_i(paddr),
        .unit_ok_o(unit_ok),
        .block_o(unit_block)
    );

    // ************************************************************
    // address decode
    // ************************************************************
    assign hit_ctrl = (addr_i == fpec_pkg::OFS_CTRL);
    assign hit_err = (addr_i == fpec_pkg::OFS_ERR_STAT);
    assign hit_ebs = (addr_i == fpec_pkg::OFS_EBS);
    assign hit_locked = hit_ctrl || hit_err || hit_ebs;
    assign wr_ctrl = wr_i && hit_ctrl && acc_en;
    assign wr_ebs = wr_i && hit_ebs && acc_en;
    assign deny_evt = (wr_i || rd_i) && hit_locked && !acc_en;
    assign busy = ctrl[fpec_pkg::CTRL_E] || ctrl[fpec_pkg::CTRL_P];

    // ************************************************************
    // control register next value
    // ************************************************************
    // a write with the enable low drops every other bit
    assign w_swe = wdata_i[fpec_pkg::CTRL_SWE];
    assign w_esu = w_swe && !err_flag && wdata_i[fpec_pkg::CTRL_ESU];
    assign w_psu = w_swe && !err_flag && wdata_i[fpec_pkg::CTRL_PSU];
    // erase and program are gated by the setup bit already held, so
    // setup and mode bits written together do not skip the setup state
    assign w_e = w_esu && ctrl[fpec_pkg::CTRL_SWE]
                 && ctrl[fpec_pkg::CTRL_ESU]
                 && wdata_i[fpec_pkg::CTRL_E];
    assign w_p = w_psu && ctrl[fpec_pkg::CTRL_SWE]
                 && ctrl[fpec_pkg::CTRL_PSU] && unit_ok
                 && wdata_i[fpec_pkg::CTRL_P];
    assign align_evt = wr_ctrl && w_psu && ctrl[fpec_pkg::CTRL_PSU]
                       && wdata_i[fpec_pkg::CTRL_P] && !unit_ok;
    assign fail_evt = fail_sync && busy && !err_flag;

    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_ctrl)
        begin
            next_ctrl[fpec_pkg::CTRL_SWE] = w_swe;
            next_ctrl[fpec_pkg::CTRL_ESU] = w_esu;
            next_ctrl[fpec_pkg::CTRL_PSU] = w_psu;
            next_ctrl[fpec_pkg::CTRL_EV] = w_swe
                                           && wdata_i[fpec_pkg::CTRL_EV];
            next_ctrl[fpec_pkg::CTRL_PV] = w_swe
                                           && wdata_i[fpec_pkg::CTRL_PV];
            next_ctrl[fpec_pkg::CTRL_E] = w_e;
            next_ctrl[fpec_pkg::CTRL_P] = w_p;
        end
        // error protection drops any running or pending operation
        if (fail_evt || err_flag)
        begin
            next_ctrl[fpec_pkg::CTRL_ESU] = 1'b0;
            next_ctrl[fpec_pkg::CTRL_PSU] = 1'b0;
            next_ctrl[fpec_pkg::CTRL_E] = 1'b0;
            next_ctrl[fpec_pkg::CTRL_P] = 1'b0;
        end
    end

    // ************************************************************
    // erase block select next value
    // ************************************************************
    always_comb
    begin
        next_ebs = ebs;
        if (wr_ebs)
        begin
            next_ebs = wdata_i[fpec_pkg::EBS_W-1:0];
        end
        if (wr_ebs && multi_hot(wdata_i[fpec_pkg::EBS_W-1:0]))
        begin
            next_ebs = fpec_pkg::EBS_RST;
        end
        // write enable low, now or after this write, holds it at zero
        if (!next_ctrl[fpec_pkg::CTRL_SWE])
        begin
            next_ebs = fpec_pkg::EBS_RST;
        end
    end

    // ************************************************************
    // interrupt status: write one clears, a new event wins
    // ************************************************************
    assign irq_evt = {align_evt, deny_evt, fail_evt};
    assign next_irq_stat = (wr_i && addr_i == fpec_pkg::OFS_IRQ_STAT)
                           ? ((irq_stat & ~wdata_i[fpec_pkg::IRQ_W-1:0]) | irq_evt)
                           : (irq_stat | irq_evt);

    // ************************************************************
    // read data mux; locked registers read zero
    // ************************************************************
    assign rd_mux =
        (hit_ctrl && acc_en) ? {1'b0, ctrl} :
        (hit_err && acc_en) ? {err_flag, 7'h00} :
        (hit_ebs && acc_en) ? {2'b00, ebs} :
        (addr_i == fpec_pkg::OFS_ACC_EN) ? {acc_en, 7'h00} :
        (addr_i == fpec_pkg::OFS_IRQ_STAT) ? {5'h00, irq_stat} :
        (addr_i == fpec_pkg::OFS_IRQ_MASK) ? {5'h00, irq_mask} :
        (addr_i == fpec_pkg::OFS_PADDR_LO) ? paddr[7:0] :
        (addr_i == fpec_pkg::OFS_PADDR_HI) ? paddr[15:8] :
        8'h00;

    // ************************************************************
    // control, block select and error flag
    // ************************************************************
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl <= fpec_pkg::CTRL_RST;
            ebs <= fpec_pkg::EBS_RST;
            err_flag <= 1'b0;
        end
        else if (ce_i)
        begin
            ctrl <= next_ctrl;
            ebs <= next_ebs;
            // read-only: only reset clears it
            err_flag <= err_flag || fail_evt;
        end
    end

    // ************************************************************
    // access enable, interrupt mask and program address
    // ************************************************************
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            acc_en <= 1'b0;
            irq_mask <= fpec_pkg::IRQ_RST;
            irq_stat <= fpec_pkg::IRQ_RST;
            paddr <= fpec_pkg::PADDR_RST;
        end
        else if (ce_i)
        begin
            irq_stat <= next_irq_stat;
            if (wr_i && addr_i == fpec_pkg::OFS_ACC_EN)
            begin
                acc_en <= wdata_i[fpec_pkg::ACC_EN_BIT];
            end
            if (wr_i && addr_i == fpec_pkg::OFS_IRQ_MASK)
            begin
                irq_mask <= wdata_i[fpec_pkg::IRQ_W-1:0];
            end
            // the target may not move under a running program pulse
            if (wr_i && addr_i == fpec_pkg::OFS_PADDR_LO && !ctrl[fpec_pkg::CTRL_P])
            begin
                paddr[7:0] <= wdata_i;
            end
            if (wr_i && addr_i == fpec_pkg::OFS_PADDR_HI && !ctrl[fpec_pkg::CTRL_P])
            begin
                paddr[15:8] <= wdata_i;
            end
        end
    end

    // ************************************************************
    // outputs: read data, interrupt and mode levels to the array
    // ************************************************************
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
            erase_setup_o <= 1'b0;
            program_setup_o <= 1'b0;
            erase_mode_o <= 1'b0;
            program_mode_o <= 1'b0;
            erase_verify_o <= 1'b0;
            program_verify_o <= 1'b0;
            error_protect_o <= 1'b0;
            erase_block_o <= 6'h00;
            prog_addr_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            // held only in the cycle after the strobe
            rdata_o <= rd_i ? rd_mux : 8'h00;
            irq_o <= |(next_irq_stat & irq_mask);
            // one level per mode, following the register each cycle
            erase_setup_o <= next_ctrl[fpec_pkg::CTRL_ESU];
            program_setup_o <= next_ctrl[fpec_pkg::CTRL_PSU];
            erase_mode_o <= next_ctrl[fpec_pkg::CTRL_E];
            program_mode_o <= next_ctrl[fpec_pkg::CTRL_P];
            erase_verify_o <= next_ctrl[fpec_pkg::CTRL_EV];
            program_verify_o <= next_ctrl[fpec_pkg::CTRL_PV];
            error_protect_o <= err_flag || fail_evt;
            // one block at most, so one erase never clears the array
            erase_block_o <= next_ebs;
            prog_addr_o <= {paddr[15:6], 6'h00};
        end
    end

    // the unit's own block is not read anywhere; it is only reduced into unused_blk
    logic unused_blk;
    assign unused_blk = ^unit_block;

endmodule // fpec_ctrl

// ===== hdl/fpec_pkg.sv
// fpec_pkg: register map, bit positions and reset values of the flash
// program/erase control block.
// assumes a byte-wide register port with a 4-bit register index.
package fpec_pkg;

    // ************************************************************
    // register port geometry
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 16;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;      // program_erase_control
    localparam logic [3:0] OFS_ERR_STAT = 4'h1;  // flash_error_status
    localparam logic [3:0] OFS_EBS = 4'h2;       // erase_block_select
    localparam logic [3:0] OFS_ACC_EN = 4'h3;    // flash_reg_access_enable
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
    localparam logic [3:0] OFS_PADDR_LO = 4'h6;
    localparam logic [3:0] OFS_PADDR_HI = 4'h7;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_RSVD = 7;
    localparam int CTRL_SWE = 6;
    localparam int CTRL_ESU = 5;
    localparam int CTRL_PSU = 4;
    localparam int CTRL_EV = 3;
    localparam int CTRL_PV = 2;
    localparam int CTRL_E = 1;
    localparam int CTRL_P = 0;
    localparam int ERR_FLAG_BIT = 7;
    localparam int ACC_EN_BIT = 7;
    localparam int IRQ_ERR = 0;      // error flag went to one
    localparam int IRQ_DENY = 1;     // access while locked out
    localparam int IRQ_ALIGN = 2;    // program entry refused, bad unit
    localparam int IRQ_W = 3;
    localparam int EBS_W = 6;

    // ************************************************************
    // reset values and array geometry
    // ************************************************************
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [5:0] EBS_RST = 6'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [15:0] PADDR_RST = 16'h0000;
    localparam int UNIT_LSB_W = 6;                 // 64-byte program unit
    localparam logic [15:0] BLK4K_0 = 16'h1000;    // first 4-kbyte block
    localparam logic [15:0] BLK4K_1 = 16'h2000;    // second 4-kbyte block
    localparam logic [15:0] FLASH_END = 16'h3000;  // first address past array

endpackage

// ===== hdl/fpec_sync2.sv
// fpec_sync2: two-flop synchroniser for a level from the flash array.
// assumes the source level is held for several mclk_i periods.
module fpec_sync2
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic sync_o
);

    logic meta;

    // ************************************************************
    // two stages; only the second stage is read outside
    // ************************************************************
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= 1'b0;
            sync_o <= 1'b0;
        end
        else if (ce_i)
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule // fpec_sync2

// ===== hdl/fpec_unit_check.sv
// fpec_unit_check: checks the programming start address and names the
// erase block that it lies in.
// assumes addresses are byte addresses from the array base.
module fpec_unit_check
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [15:0] addr_i,
    output logic unit_ok_o,
    output logic [5:0] block_o
);

    logic aligned;
    logic in_range;
    logic [5:0] blk;

    // ************************************************************
    // decode; the low six bits zero gives 00, 40, 80 or c0 in the low byte
    // ************************************************************
    assign aligned = (addr_i[fpec_pkg::UNIT_LSB_W-1:0] == 6'h00);
    assign in_range = (addr_i < fpec_pkg::FLASH_END);
    assign blk = !in_range ? 6'h00 :
                 (addr_i >= fpec_pkg::BLK4K_1) ? 6'h20 :
                 (addr_i >= fpec_pkg::BLK4K_0) ? 6'h10 :
                 6'(6'h01 << addr_i[11:10]);

    // registered so the result reaches the control logic glitch free
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            unit_ok_o <= 1'b0;
            block_o <= 6'h00;
        end
        else if (ce_i)
        begin
            unit_ok_o <= aligned && in_range;
            block_o <= blk;
        end
    end

endmodule // fpec_unit_check

// ===== verif/fpec_ctrl_properties.sv
// fpec_ctrl_properties: concurrent checks on the ports of fpec_ctrl.
// assumes one clock domain, mclk_i, with rst_b_i low as reset.
module fpec_ctrl_properties
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
)
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic erase_setup_o,
    input wire logic program_setup_o,
    input wire logic erase_mode_o,
    input wire logic program_mode_o,
    input wire logic erase_verify_o,
    input wire logic program_verify_o,
    input wire logic error_protect_o,
    input wire logic [5:0] erase_block_o,
    input wire logic [15:0] prog_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // access enable shadow and sequences
    // ************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic acc_q;
    // shadow of the access enable bit, so gated writes can be told apart
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            acc_q <= 1'b0;
        else if (ce_i && wr_i && addr_i == fpec_pkg::OFS_ACC_EN)
            acc_q <= wdata_i[fpec_pkg::ACC_EN_BIT];
    end
    sequence ctrl_wr;
        ce_i && wr_i && acc_q && addr_i == fpec_pkg::OFS_CTRL;
    endsequence
    sequence enable_off_wr;
        ctrl_wr ##0 !wdata_i[fpec_pkg::CTRL_SWE];
    endsequence
    sequence enable_on_wr;
        ctrl_wr ##0 wdata_i[fpec_pkg::CTRL_SWE];
    endsequence
    // ************************************************************
    // assertions
    // ************************************************************
    a_rdata_idle: assert property ((ce_i && !rd_i) |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_rsvd_zero: assert property ((ce_i && rd_i && addr_i == fpec_pkg::OFS_CTRL) |=> !rdata_o[7])
        else $error("reserved control bit read as one");
    a_enable_clear: assert property (enable_off_wr |=> !(erase_setup_o || program_setup_o
        || erase_mode_o || program_mode_o || erase_verify_o || program_verify_o)
        && erase_block_o == 6'h00)
        else $error("mode or block bit kept with write enable low");
    a_verify_follow: assert property (enable_on_wr |=>
        erase_verify_o == $past(wdata_i[3]) && program_verify_o == $past(wdata_i[2]))
        else $error("verify level does not follow control write");
    a_erase_gate: assert property ($rose(erase_mode_o) |-> $past(erase_setup_o))
        else $error("erase mode entered without held erase setup");
    a_prog_gate: assert property ($rose(program_mode_o) |-> $past(program_setup_o))
        else $error("program mode entered without held program setup");
    a_prog_unit: assert property (program_mode_o |->
        prog_addr_o[5:0] == 6'h00 && prog_addr_o < 16'h3000)
        else $error("program mode on a bad unit address");
    a_block_multi: assert property ((ce_i && wr_i && acc_q && addr_i == fpec_pkg::OFS_EBS
        && $countones(wdata_i[5:0]) > 1) |=> erase_block_o == 6'h00)
        else $error("several block bits not cleared");
    a_err_hold: assert property (error_protect_o |=> error_protect_o
        && !erase_mode_o && !program_mode_o)
        else $error("error protection released or mode kept");
    a_locked_read: assert property ((ce_i && rd_i && !acc_q
        && addr_i <= fpec_pkg::OFS_EBS) |=> rdata_o == 8'h00)
        else $error("locked register read returned data");
endmodule // fpec_ctrl_properties

// ===== verif/fpec_flash_model.sv
// fpec_flash_model: behavioural flash array behind fpec_ctrl.
// assumes mode levels from the controller; fail_req_i comes from the bench.
module fpec_flash_model
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic erase_mode_i,
    input wire logic program_mode_i,
    input wire logic [5:0] erase_block_i,
    input wire logic fail_req_i,
    output logic array_fail_o,
    output logic [5:0] erased_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // array behaviour
    // ************************************************************
    // a failure exists only during a live operation
    assign array_fail_o = fail_req_i && (erase_mode_i || program_mode_i);
    // erase acts on the selected block only
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            erased_o <= 6'h00;
        else if (erase_mode_i)
            erased_o <= erased_o | erase_block_i;
    end
endmodule // fpec_flash_model

// ===== verif/tb_top.sv
// tb_top: self-checking bench for fpec_ctrl with a flash array model.
// assumes fpec_pkg and the design files are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic fail_req = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o, array_fail_i, set_er, set_pg, md_er, md_pg, vf_er, vf_pg, prot;
    logic [5:0] blk, erased;
    logic [15:0] paddr;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;
    fpec_ctrl i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .array_fail_i(array_fail_i), .erase_setup_o(set_er), .program_setup_o(set_pg),
        .erase_mode_o(md_er), .program_mode_o(md_pg), .erase_verify_o(vf_er),
        .program_verify_o(vf_pg), .error_protect_o(prot), .erase_block_o(blk),
        .prog_addr_o(paddr));
    fpec_flash_model i_flash (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .erase_mode_i(md_er),
        .program_mode_i(md_pg), .erase_block_i(blk), .fail_req_i(fail_req),
        .array_fail_o(array_fail_i), .erased_o(erased));
    // ************************************************************
    // bus tasks and checks
    // ************************************************************
    task automatic test_done();
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ends at the falling edge, outputs settled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(negedge mclk_i);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        chk($sformatf("reg %0h", a), {8'h00, rdata_o}, {8'h00, exp});
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        for (int a = 3; a < 9; a++)
            rd(a[3:0], 8'h00);
    endtask
    task automatic t_lock();
        wr(4'h0, 8'h40);
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h02);
        chk("irq", {15'h0, irq_o}, 16'h0000);
        wr(4'h5, 8'h02);
        @(negedge mclk_i);
        chk("irq", {15'h0, irq_o}, 16'h0001);
        wr(4'h4, 8'h02);
        @(negedge mclk_i);
        chk("irq", {15'h0, irq_o}, 16'h0000);
        rd(4'h4, 8'h00);
        rd(4'h5, 8'h02);
    endtask
    task automatic t_gate();
        wr(4'h3, 8'h80);
        rd(4'h3, 8'h80);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'h3f);
        rd(4'h0, 8'h00);
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00);
        wr(4'h0, 8'h60);
        chk("erase setup", {15'h0, set_er}, 16'h0001);
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(4'h0, 8'h20);
        chk("erase setup", {15'h0, set_er}, 16'h0001);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        wr(4'h0, 8'h20);
        chk("erase setup", {15'h0, set_er}, 16'h0000);
    endtask
    task automatic t_erase();
        wr(4'h0, 8'h40);
        wr(4'h0, 8'h62);
        chk("erase mode", {15'h0, md_er}, 16'h0000);
        rd(4'h0, 8'h60);
        wr(4'h2, 8'h03);
        rd(4'h2, 8'h00);
        // software clears the whole array one block at a time
        for (int b = 0; b < 6; b++)
        begin
            wr(4'h2, 8'h01 << b);
            chk("block", {10'h0, blk}, 16'h0001 << b);
            wr(4'h0, 8'h62);
            chk("erase mode", {15'h0, md_er}, 16'h0001);
            wr(4'h0, 8'h60);
            chk("erase mode", {15'h0, md_er}, 16'h0000);
        end
        chk("erased", {10'h0, erased}, 16'h003f);
        wr(4'h0, 8'h40);
        chk("erase setup", {15'h0, set_er}, 16'h0000);
        wr(4'h0, 8'h48);
        chk("erase verify", {15'h0, vf_er}, 16'h0001);
        wr(4'h0, 8'h44);
        chk("erase verify", {15'h0, vf_er}, 16'h0000);
        chk("prog verify", {15'h0, vf_pg}, 16'h0001);
        wr(4'h0, 8'h40);
    endtask
    task automatic t_prog();
        logic [15:0] ta [4] = '{16'h00c0, 16'h0041, 16'h3000, 16'h2fc0};
        logic ok;
        wr(4'h0, 8'h41);
        chk("prog mode", {15'h0, md_pg}, 16'h0000);
        foreach (ta[i])
        begin
            ok = (ta[i][5:0] == 6'h00) && (ta[i] < 16'h3000);
            wr(4'h6, ta[i][7:0]);
            wr(4'h7, ta[i][15:8]);
            wr(4'h0, 8'h50);
            chk("prog setup", {15'h0, set_pg}, 16'h0001);
            wr(4'h0, 8'h51);
            chk("prog mode", {15'h0, md_pg}, {15'h0, ok});
            chk("prog addr", paddr, ta[i] & 16'hffc0);
            rd(4'h4, {5'h00, !ok, 2'b00});
            wr(4'h4, 8'h04);
            wr(4'h0, 8'h40);
        end
    endtask
    task automatic t_error();
        wr(4'h0, 8'h50);
        wr(4'h0, 8'h51);
        chk("prog mode", {15'h0, md_pg}, 16'h0001);
        fail_req <= 1'b1;
        for (int i = 0; i < 10 && prot !== 1'b1; i++)
            @(negedge mclk_i);
        chk("protect", {15'h0, prot}, 16'h0001);
        chk("prog mode", {15'h0, md_pg}, 16'h0000);
        fail_req <= 1'b0;
        rd(4'h1, 8'h80);
        rd(4'h4, 8'h01);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h80);
        wr(4'h0, 8'h60);
        chk("erase setup", {15'h0, set_er}, 16'h0000);
        wr(4'h0, 8'h48);
        chk("erase verify", {15'h0, vf_er}, 16'h0001);
    endtask
    // ************************************************************
    // sequence and hang guard
    // ************************************************************
    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_lock();
        t_gate();
        t_erase();
        t_prog();
        t_error();
        test_done();
    end
    // whole run needs well under 1500 cycles
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            test_done();
        end
    end
endmodule // tb_top

bind fpec_ctrl fpec_ctrl_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_props (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .erase_setup_o(erase_setup_o),
    .program_setup_o(program_setup_o), .erase_mode_o(erase_mode_o),
    .program_mode_o(program_mode_o), .erase_verify_o(erase_verify_o),
    .program_verify_o(program_verify_o), .error_protect_o(error_protect_o),
    .erase_block_o(erase_block_o), .prog_addr_o(prog_addr_o));
